//--- design/two_wire_target.sv
// Purpose: two-wire bus target with Avalon-MM register access
// Assumes: bus pins are synchronous to clk_sys; open-drain drivers outside
// Notes:   controller role is never entered, so the role flag reads zero
`default_nettype none

module two_wire_target
	import two_wire_target_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        reset,
	input  wire logic [7:0]  address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [31:0] writedata,
	output logic      [31:0] readdata,
	output logic             waitrequest,
	output logic             irq,
	input  wire logic        serial_clock_pin,
	input  wire logic        serial_data_pin,
	output logic             scl_out,
	output logic             scl_oe,
	output logic             sda_out,
	output logic             sda_oe
);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	target_state_type state_reg;
	logic [7:0]  control_register;
	logic [7:0]  clock_control_reg;
	logic [7:0]  own_address_reg_one;
	logic [7:0]  own_address_reg_two;
	logic [7:0]  data_register;
	logic [7:0]  shift_reg;
	logic [3:0]  bit_cnt_reg;
	logic [8:0]  delay_reg;
	logic        served_reg;
	logic        scl_q_reg;
	logic        sda_q_reg;
	logic        sda_drv_reg;
	logic        scl_hold_reg;
	logic        address_matched_flag;
	logic        byte_done_flag;
	logic        stop_seen_flag;
	logic        bus_error_flag;
	logic        ack_failure_flag;
	logic        gcall_hit_reg;
	logic        tx_dir_reg;
	logic        tx_loaded_reg;
	logic        ten_hdr_reg;
	logic        ten_done_reg;
	logic        busy_reg;
	logic        sr1_seen_reg;
	logic        release_reg;
	logic        event_flag;
	logic        controller_role_flag;
	logic        rd_go;
	logic        wr_go;
	logic        sr1_rd;
	logic        sr2_rd;
	logic        dr_rd;
	logic        dr_wr;
	logic        cr_wr;
	logic        scl_rise;
	logic        scl_fall;
	logic        start_det;
	logic        stop_det;
	logic        in_byte;
	logic        hold_cond;
	logic        ack_en;
	logic        ten_mode;
	logic        hdr_hit;
	logic        own7_hit;
	logic        gc_hit;
	logic [8:0]  div_load;

	// ------------------------------------------------------------
	// register read mux
	// ------------------------------------------------------------
	function automatic logic [7:0] reg_value(input logic [7:0] ofs);
		logic [7:0] v;
		v = 8'h00;
		unique case (ofs)
			CONTROL_OFS:      v = control_register;
			STATUS_ONE_OFS: begin
				v[ST1_EVENT_BIT] = event_flag;
				v[ST1_ADDR_BIT]  = address_matched_flag;
				v[ST1_BYTE_BIT]  = byte_done_flag;
				v[ST1_TX_BIT]    = tx_dir_reg;
				v[ST1_BUSY_BIT]  = busy_reg;
				v[ST1_ROLE_BIT]  = controller_role_flag;
			end
			STATUS_TWO_OFS: begin
				v[ST2_STOP_BIT]  = stop_seen_flag;
				v[ST2_BUS_ERROR_FLAG_BIT]  = bus_error_flag;
				v[ST2_AF_BIT]    = ack_failure_flag;
				v[ST2_GCALL_BIT] = gcall_hit_reg;
			end
			CLOCK_CTRL_OFS:   v = clock_control_reg;
			OWN_ADDR_ONE_OFS: v = own_address_reg_one;
			OWN_ADDR_TWO_OFS: v = own_address_reg_two;
			DATA_OFS:         v = data_register;
			default:          v = 8'h00;
		endcase
		return v;
	endfunction : reg_value

	// ------------------------------------------------------------
	// Avalon slave: one wait state, effects at the released edge
	// ------------------------------------------------------------
	assign waitrequest = (read | write) & ~served_reg;
	assign rd_go  = read & served_reg;
	assign wr_go  = write & served_reg;
	assign sr1_rd = rd_go & (address == STATUS_ONE_OFS);
	assign sr2_rd = rd_go & (address == STATUS_TWO_OFS);
	assign dr_rd  = rd_go & (address == DATA_OFS);
	assign dr_wr  = wr_go & (address == DATA_OFS);
	assign cr_wr  = wr_go & (address == CONTROL_OFS);

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			served_reg <= 1'b0;
			readdata   <= 32'h0000_0000;
		end else begin
			served_reg <= (read | write) & ~served_reg;
			if (read & ~served_reg)
				readdata <= {24'h00_0000, reg_value(address)};
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			control_register    <= CONTROL_RESET;
			clock_control_reg   <= CLOCK_RESET;
			own_address_reg_one <= OWN_ONE_RESET;
			own_address_reg_two <= OWN_TWO_RESET;
		end else if (wr_go) begin
			unique case (address)
				CONTROL_OFS:      control_register    <= writedata[7:0];
				CLOCK_CTRL_OFS:   clock_control_reg   <= writedata[7:0];
				OWN_ADDR_ONE_OFS: own_address_reg_one <= writedata[7:0];
				OWN_ADDR_TWO_OFS: own_address_reg_two <= writedata[7:0];
				default: ;
			endcase
		end
	end

	// byte done clears only on status one read followed by a data access
	always_ff @(posedge clk_sys) begin
		if (reset)
			sr1_seen_reg <= 1'b0;
		else if (dr_rd | dr_wr)
			sr1_seen_reg <= 1'b0;
		else if (sr1_rd & byte_done_flag)
			sr1_seen_reg <= 1'b1;
	end

	assign event_flag = address_matched_flag | byte_done_flag | stop_seen_flag
		| bus_error_flag | ack_failure_flag;
	assign controller_role_flag = 1'b0;
	assign irq = control_register[CTRL_IRQ_EN_BIT] & event_flag;

	// ------------------------------------------------------------
	// line sampling and condition detect
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			scl_q_reg <= 1'b1;
			sda_q_reg <= 1'b1;
		end else begin
			scl_q_reg <= serial_clock_pin;
			sda_q_reg <= serial_data_pin;
		end
	end

	assign scl_rise  = serial_clock_pin & ~scl_q_reg;
	assign scl_fall  = ~serial_clock_pin & scl_q_reg;
	assign start_det = scl_q_reg & serial_clock_pin & sda_q_reg & ~serial_data_pin;
	assign stop_det  = scl_q_reg & serial_clock_pin & ~sda_q_reg & serial_data_pin;
	// a stop or repeated start legally sits in the first clock high of a byte
	assign in_byte   = ((state_reg == ADDR || state_reg == RX_BITS) && bit_cnt_reg > 4'h1)
		|| (state_reg == TX_BITS && bit_cnt_reg != 4'h0);

	// ------------------------------------------------------------
	// address compare
	// ------------------------------------------------------------
	assign ack_en   = control_register[CTRL_ACK_EN_BIT];
	assign ten_mode = own_address_reg_two[OWN_ADDRESS_REG_TWO_TEN_BIT];
	assign hdr_hit  = ten_mode && shift_reg[7:3] == TEN_BIT_HEADER
		&& shift_reg[2:1] == own_address_reg_two[OWN_ADDRESS_REG_TWO_HI_LSB +: 2];
	assign own7_hit = ~ten_mode && shift_reg[7:1] == own_address_reg_one[7:1];
	assign gc_hit   = control_register[CTRL_GCALL_EN_BIT] && shift_reg == GENERAL_CALL;

	// ------------------------------------------------------------
	// clock stretch with divider-timed release
	// ------------------------------------------------------------
	// the release delay gives data setup before the master sees scl high
	assign div_load = (clock_control_reg[CCR_FAST_BIT] ? {2'b00, clock_control_reg[6:0]}
		: {1'b0, clock_control_reg[6:0], 1'b0})
		+ {6'h00, own_address_reg_two[OWN_ADDRESS_REG_TWO_FR_LSB +: 3]};

	assign hold_cond = (state_reg == HOLD_ADDR && address_matched_flag)
		|| (state_reg == RX_HOLD && byte_done_flag)
		|| (state_reg == TX_WAIT && (byte_done_flag || ~tx_loaded_reg));

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			scl_hold_reg <= 1'b0;
			delay_reg    <= 9'h000;
		end else if (hold_cond) begin
			scl_hold_reg <= 1'b1;
			delay_reg    <= div_load;
		end else if (scl_hold_reg && delay_reg != 9'h000) begin
			delay_reg    <= delay_reg - 9'h001;
		end else begin
			scl_hold_reg <= 1'b0;
		end
	end

	assign scl_out = 1'b0;
	assign sda_out = 1'b0;
	assign scl_oe  = scl_hold_reg;
	assign sda_oe  = sda_drv_reg;

	// ------------------------------------------------------------
	// protocol engine and flags (set wins over clear)
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			state_reg            <= IDLE;
			shift_reg            <= 8'h00;
			bit_cnt_reg          <= 4'h0;
			sda_drv_reg          <= 1'b0;
			data_register        <= 8'h00;
			address_matched_flag <= 1'b0;
			byte_done_flag       <= 1'b0;
			stop_seen_flag       <= 1'b0;
			bus_error_flag       <= 1'b0;
			ack_failure_flag     <= 1'b0;
			gcall_hit_reg        <= 1'b0;
			tx_dir_reg           <= 1'b0;
			tx_loaded_reg        <= 1'b0;
			ten_hdr_reg          <= 1'b0;
			ten_done_reg         <= 1'b0;
			busy_reg             <= 1'b0;
			release_reg          <= 1'b0;
		end else begin
			address_matched_flag <= address_matched_flag & ~sr1_rd;
			byte_done_flag       <= byte_done_flag & ~((dr_rd | dr_wr) & sr1_seen_reg);
			stop_seen_flag       <= stop_seen_flag & ~sr2_rd;
			bus_error_flag       <= bus_error_flag & ~sr2_rd;
			ack_failure_flag     <= ack_failure_flag & ~sr2_rd;
			gcall_hit_reg        <= gcall_hit_reg & ~sr2_rd;
			if (dr_wr) begin
				data_register <= writedata[7:0];
				tx_loaded_reg <= 1'b1;
			end
			if (cr_wr && control_register[CTRL_STOP_BIT] && ~writedata[CTRL_STOP_BIT]
				&& byte_done_flag)
				release_reg <= 1'b1;
			if (start_det)
				busy_reg <= 1'b1;
			if (stop_det)
				busy_reg <= 1'b0;

			if (~control_register[CTRL_ENABLE_BIT]) begin
				state_reg   <= IDLE;
				sda_drv_reg <= 1'b0;
			end else if (stop_det) begin
				if (in_byte)
					bus_error_flag <= 1'b1;
				else if (state_reg != IDLE && state_reg != HALT)
					stop_seen_flag <= 1'b1;
				state_reg    <= IDLE;
				sda_drv_reg  <= 1'b0;
				ten_done_reg <= 1'b0;
				release_reg  <= 1'b0;
			end else if (start_det) begin
				if (in_byte)
					bus_error_flag <= 1'b1;
				state_reg   <= ADDR;
				bit_cnt_reg <= 4'h0;
				sda_drv_reg <= 1'b0;
				ten_hdr_reg <= 1'b0;
			end else begin
				unique case (state_reg)
					IDLE: ;
					ADDR, RX_BITS: begin
						if (scl_rise) begin
							shift_reg   <= {shift_reg[6:0], serial_data_pin};
							bit_cnt_reg <= bit_cnt_reg + 4'h1;
						end else if (scl_fall && bit_cnt_reg == BITS_PER_BYTE) begin
							bit_cnt_reg <= 4'h0;
							if (state_reg == RX_BITS) begin
								sda_drv_reg <= ack_en;
								state_reg   <= RX_ACK;
							end else if (ten_hdr_reg) begin
								ten_hdr_reg <= 1'b0;
								if (shift_reg == own_address_reg_one) begin
									sda_drv_reg  <= ack_en;
									tx_dir_reg   <= 1'b0;
									ten_done_reg <= 1'b1;
									state_reg    <= ADDR_ACK;
								end else begin
									state_reg <= IDLE;
								end
							end else if (hdr_hit && ~shift_reg[0]) begin
								sda_drv_reg <= ack_en;
								ten_hdr_reg <= 1'b1;
								state_reg   <= ADDR_ACK;
							end else if (hdr_hit && ten_done_reg) begin
								sda_drv_reg <= ack_en;
								tx_dir_reg  <= 1'b1;
								state_reg   <= ADDR_ACK;
							end else if (own7_hit || gc_hit) begin
								sda_drv_reg   <= ack_en;
								tx_dir_reg    <= own7_hit & shift_reg[0];
								gcall_hit_reg <= gc_hit & ~own7_hit;
								state_reg     <= ADDR_ACK;
							end else begin
								state_reg <= IDLE;
							end
						end
					end
					ADDR_ACK: begin
						if (scl_fall) begin
							sda_drv_reg <= 1'b0;
							if (ten_hdr_reg) begin
								state_reg <= ADDR;
							end else begin
								address_matched_flag <= 1'b1;
								data_register        <= shift_reg;
								state_reg            <= HOLD_ADDR;
							end
						end
					end
					HOLD_ADDR: begin
						if (release_reg) begin
							release_reg <= 1'b0;
							state_reg   <= IDLE;
						end else if (~address_matched_flag) begin
							bit_cnt_reg <= 4'h0;
							state_reg   <= tx_dir_reg ? TX_WAIT : RX_BITS;
						end
					end
					RX_ACK: begin
						if (scl_fall) begin
							sda_drv_reg    <= 1'b0;
							data_register  <= shift_reg;
							byte_done_flag <= 1'b1;
							state_reg      <= RX_HOLD;
						end
					end
					RX_HOLD: begin
						if (release_reg) begin
							release_reg <= 1'b0;
							state_reg   <= IDLE;
						end else if (~byte_done_flag) begin
							state_reg <= RX_BITS;
						end
					end
					TX_WAIT: begin
						if (release_reg) begin
							release_reg <= 1'b0;
							state_reg   <= IDLE;
						end else if (~byte_done_flag && tx_loaded_reg) begin
							sda_drv_reg   <= ~data_register[7];
							shift_reg     <= {data_register[6:0], 1'b0};
							tx_loaded_reg <= 1'b0;
							bit_cnt_reg   <= 4'h0;
							state_reg     <= TX_BITS;
						end
					end
					TX_BITS: begin
						if (scl_fall) begin
							bit_cnt_reg <= bit_cnt_reg + 4'h1;
							if (bit_cnt_reg == BITS_PER_BYTE - 4'h1) begin
								sda_drv_reg <= 1'b0;
								bit_cnt_reg <= 4'h0;
								state_reg   <= TX_ACKCHK;
							end else begin
								sda_drv_reg <= ~shift_reg[7];
								shift_reg   <= {shift_reg[6:0], 1'b0};
							end
						end
					end
					TX_ACKCHK: begin
						if (scl_rise) begin
							if (serial_data_pin) begin
								ack_failure_flag <= 1'b1;
								state_reg        <= HALT;
							end else begin
								byte_done_flag <= 1'b1;
								state_reg      <= TX_ACKEND;
							end
						end
					end
					TX_ACKEND: begin
						if (scl_fall)
							state_reg <= TX_WAIT;
					end
					HALT: begin
						if (release_reg) begin
							release_reg <= 1'b0;
							sda_drv_reg <= 1'b0;
							state_reg   <= IDLE;
						end
					end
					default: state_reg <= IDLE;
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	addr_stretch_a: assert property (@(posedge clk_sys) disable iff (reset)
		state_reg == HOLD_ADDR && address_matched_flag |=> scl_oe)
		else $error("clock not held after address match");
	ack_gate_a: assert property (@(posedge clk_sys) disable iff (reset)
		state_reg == RX_BITS && scl_fall && bit_cnt_reg == BITS_PER_BYTE && ~ack_en
		&& ~stop_det && ~start_det |=> ~sda_oe)
		else $error("acknowledge driven while disabled");
	stop_flag_a: assert property (@(posedge clk_sys) disable iff (reset)
		stop_det && ~in_byte && state_reg == RX_BITS && control_register[CTRL_ENABLE_BIT]
		|=> stop_seen_flag && state_reg == IDLE)
		else $error("stop not flagged");
	bus_error_a: assert property (@(posedge clk_sys) disable iff (reset)
		start_det && in_byte && control_register[CTRL_ENABLE_BIT]
		|=> bus_error_flag && state_reg == ADDR && bit_cnt_reg == 4'h0)
		else $error("misplaced start not flagged");
	nack_fail_a: assert property (@(posedge clk_sys) disable iff (reset)
		state_reg == TX_ACKCHK && scl_rise && serial_data_pin && ~stop_det && ~start_det
		&& control_register[CTRL_ENABLE_BIT] |=> ack_failure_flag && event_flag)
		else $error("non-acknowledge not flagged");
	halt_free_a: assert property (@(posedge clk_sys) disable iff (reset)
		state_reg == HALT ##1 state_reg == HALT |-> ~scl_oe)
		else $error("clock held after failure");
	rx_stretch_a: assert property (@(posedge clk_sys) disable iff (reset)
		state_reg == RX_HOLD && byte_done_flag |=> scl_oe)
		else $error("clock not held after receive");
	tx_stretch_a: assert property (@(posedge clk_sys) disable iff (reset)
		state_reg == TX_WAIT && ~tx_loaded_reg |=> scl_oe)
		else $error("clock not held for transmit byte");
	hold_release_a: assert property (@(posedge clk_sys) disable iff (reset)
		scl_oe && ~hold_cond && delay_reg == 9'h000 |=> ~scl_oe)
		else $error("stretch not released after delay");

endmodule : two_wire_target

`default_nettype wire

//--- design/two_wire_target_pkg.sv
// Purpose: constants for the two-wire bus target interface
// Assumes: byte addresses on a 32-bit Avalon-MM slave
// Notes:   fields sit in the low byte of each word
`default_nettype none

package two_wire_target_pkg;

	// ------------------------------------------------------------
	// register byte offsets
	// ------------------------------------------------------------
	localparam logic [7:0] CONTROL_OFS      = 8'h20;
	localparam logic [7:0] STATUS_ONE_OFS   = 8'h24;
	localparam logic [7:0] STATUS_TWO_OFS   = 8'h28;
	localparam logic [7:0] CLOCK_CTRL_OFS   = 8'h2c;
	localparam logic [7:0] OWN_ADDR_ONE_OFS = 8'h30;
	localparam logic [7:0] OWN_ADDR_TWO_OFS = 8'h34;
	localparam logic [7:0] DATA_OFS         = 8'h38;

	// ------------------------------------------------------------
	// control register fields
	// ------------------------------------------------------------
	localparam int CTRL_ENABLE_BIT   = 0;
	localparam int CTRL_IRQ_EN_BIT   = 1;
	localparam int CTRL_STOP_BIT     = 2;
	localparam int CTRL_ACK_EN_BIT   = 4;
	localparam int CTRL_GCALL_EN_BIT = 5;

	// ------------------------------------------------------------
	// status fields
	// ------------------------------------------------------------
	localparam int ST1_EVENT_BIT  = 0;
	localparam int ST1_ADDR_BIT   = 1;
	localparam int ST1_BYTE_BIT   = 2;
	localparam int ST1_TX_BIT     = 3;
	localparam int ST1_BUSY_BIT   = 4;
	localparam int ST1_ROLE_BIT   = 5;
	localparam int ST2_STOP_BIT   = 0;
	localparam int ST2_BUS_ERROR_FLAG_BIT   = 1;
	localparam int ST2_AF_BIT     = 2;
	localparam int ST2_GCALL_BIT  = 3;

	// ------------------------------------------------------------
	// clock control and own address two fields
	// ------------------------------------------------------------
	localparam int CCR_FAST_BIT   = 7;
	localparam int OWN_ADDRESS_REG_TWO_TEN_BIT   = 0;
	localparam int OWN_ADDRESS_REG_TWO_HI_LSB    = 1;
	localparam int OWN_ADDRESS_REG_TWO_FR_LSB    = 5;

	// ------------------------------------------------------------
	// reset values and fixed patterns
	// ------------------------------------------------------------
	localparam logic [7:0] CONTROL_RESET  = 8'h00;
	localparam logic [7:0] CLOCK_RESET    = 8'h00;
	localparam logic [7:0] OWN_ONE_RESET  = 8'h00;
	localparam logic [7:0] OWN_TWO_RESET  = 8'h00;
	localparam logic [4:0] TEN_BIT_HEADER = 5'h1e;
	localparam logic [7:0] GENERAL_CALL   = 8'h00;
	localparam logic [3:0] BITS_PER_BYTE  = 4'h8;

	typedef enum logic [3:0] {
		IDLE, ADDR, ADDR_ACK, HOLD_ADDR, RX_BITS, RX_ACK, RX_HOLD,
		TX_WAIT, TX_BITS, TX_ACKCHK, TX_ACKEND, HALT
	} target_state_type;

endpackage : two_wire_target_pkg

`default_nettype wire

//--- sim/ctl_model.sv
// Purpose: behavioural two-wire bus controller that drives the target
// Assumes: pull-ups on both lines, wired-and with the target enables
// Notes:   bit phases are a few clk_sys cycles, far faster than a real bus
`default_nettype none

module ctl_model (
	input  wire logic clk_sys,
	input  wire logic scl_oe,
	input  wire logic sda_oe,
	output logic      serial_clock_pin,
	output logic      serial_data_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	logic scl_low = 1'b0;
	logic sda_low = 1'b0;
	int   stuck   = 0;

	// ------------------------------------------------------------
	// open-drain lines, a released line floats to the pull-up
	// ------------------------------------------------------------
	assign serial_clock_pin = ~(scl_low | scl_oe);
	assign serial_data_pin  = ~(sda_low | sda_oe);

	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
	endtask : tick

	// the target may stretch, so wait for the line itself, bounded
	task automatic scl_up;
		int w;
		w = 0;
		scl_low <= 1'b0;
		@(posedge clk_sys);
		while (serial_clock_pin !== 1'b1 && w < 5000) begin
			@(posedge clk_sys);
			w++;
		end
		if (w >= 5000) begin
			stuck++;
			tb.finish_test();
		end
	endtask : scl_up

	task automatic bit_cycle(input logic b, output logic seen);
		sda_low <= ~b;
		tick(3);
		scl_up();
		tick(3);
		seen = serial_data_pin;
		scl_low <= 1'b1;
		tick(2);
	endtask : bit_cycle

	task automatic start_cond;
		sda_low <= 1'b0;
		tick(2);
		scl_up();
		tick(3);
		sda_low <= 1'b1;
		tick(3);
		scl_low <= 1'b1;
		tick(2);
	endtask : start_cond

	// only called with the clock low, else it would form a start
	task automatic stop_cond;
		sda_low <= 1'b1;
		scl_low <= 1'b1;
		tick(3);
		scl_up();
		tick(3);
		sda_low <= 1'b0;
		tick(4);
	endtask : stop_cond

	task automatic send_byte(input logic [7:0] b, output logic acked);
		logic s;
		for (int i = 7; i >= 0; i--) bit_cycle(b[i], s);
		bit_cycle(1'b1, s);
		acked = ~s;
	endtask : send_byte

	task automatic recv_byte(input logic ack, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) bit_cycle(1'b1, d[i]);
		bit_cycle(~ack, s);
	endtask : recv_byte
endmodule : ctl_model

`default_nettype wire

//--- sim/tb.sv
// Purpose: self-checking bench for the two-wire bus target
// Assumes: registers over Avalon-MM, controller model on the lines
// Notes:   controller role is not exercised; divider left at zero
`default_nettype none
`define CHECK(g, e) begin total_checks++; if ((g) !== (e)) begin num_errors++; $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end

module tb
	import two_wire_target_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_sys   = 1'b0;
	logic        reset     = 1'b1;
	logic [7:0]  address   = 8'h00;
	logic        read      = 1'b0;
	logic        write     = 1'b0;
	logic [31:0] writedata = 32'h0;
	logic [31:0] readdata, q;
	logic        waitrequest, irq, scl_out, scl_oe, sda_out, sda_oe, scl_pin, sda_pin, ak;
	logic [7:0]  rb;
	int          num_errors = 0;
	int          total_checks = 0;

	always #2.5 clk_sys = ~clk_sys;

	two_wire_target i_two_wire_target (.clk_sys(clk_sys), .reset(reset), .address(address), .read(read),
		.write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .irq(irq),
		.serial_clock_pin(scl_pin), .serial_data_pin(sda_pin), .scl_out(scl_out), .scl_oe(scl_oe),
		.sda_out(sda_out), .sda_oe(sda_oe));
	ctl_model i_ctl_model (.clk_sys(clk_sys), .scl_oe(scl_oe), .sda_oe(sda_oe), .serial_clock_pin(scl_pin),
		.serial_data_pin(sda_pin));

	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic finish_test;
		num_errors += i_ctl_model.stuck;
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : finish_test

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
	endtask : cyc

	// the extra edge after release keeps back-to-back requests apart
	task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
		int n;
		n = 0;
		address <= a;
		writedata <= {24'h000000, d};
		write <= wr;
		read <= ~wr;
		@(posedge clk_sys);
		while (waitrequest !== 1'b0) begin
			if (++n > 50) begin
				num_errors++;
				finish_test();
			end
			@(posedge clk_sys);
		end
		q = readdata;
		write <= 1'b0;
		read <= 1'b0;
		@(posedge clk_sys);
	endtask : bus

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic sc_regs;
		bus(0, STATUS_ONE_OFS, 8'h00);
		`CHECK(q[ST1_ROLE_BIT], 1'b0)
		`CHECK({scl_out, sda_out}, 2'b00)
		bus(1, CLOCK_CTRL_OFS, 8'h85);
		bus(0, CLOCK_CTRL_OFS, 8'h00);
		`CHECK(q, 32'h00000085)
		bus(1, OWN_ADDR_TWO_OFS, 8'he0);
		bus(0, OWN_ADDR_TWO_OFS, 8'h00);
		`CHECK(q, 32'h000000e0)
		bus(1, 8'h3c, 8'hff);
		bus(0, 8'h3c, 8'h00);
		`CHECK(q, 32'h0)
		bus(1, CLOCK_CTRL_OFS, 8'h00);
	endtask : sc_regs

	task automatic sc_rx;
		bus(1, OWN_ADDR_TWO_OFS, 8'h00);
		bus(1, OWN_ADDR_ONE_OFS, 8'h52);
		bus(1, CONTROL_OFS, 8'h13);
		i_ctl_model.start_cond();
		i_ctl_model.send_byte(8'h52, ak);
		cyc(3);
		`CHECK({ak, irq, scl_oe}, 3'b111)
		bus(0, STATUS_ONE_OFS, 8'h00);
		`CHECK(q[2:0], 3'b011)
		bus(0, DATA_OFS, 8'h00);
		`CHECK(q[7:0], 8'h52)
		i_ctl_model.send_byte(8'ha5, ak);
		cyc(3);
		`CHECK({ak, scl_oe}, 2'b11)
		bus(0, STATUS_ONE_OFS, 8'h00);
		`CHECK(q[2:0], 3'b101)
		cyc(10);
		`CHECK(scl_oe, 1'b1)
		bus(0, DATA_OFS, 8'h00);
		`CHECK(q[7:0], 8'ha5)
		i_ctl_model.stop_cond();
		bus(0, STATUS_TWO_OFS, 8'h00);
		`CHECK(q[3:0], 4'h1)
		bus(0, STATUS_TWO_OFS, 8'h00);
		`CHECK(q[3:0], 4'h0)
	endtask : sc_rx

	task automatic sc_release;
		i_ctl_model.start_cond();
		i_ctl_model.send_byte(8'h52, ak);
		bus(0, STATUS_ONE_OFS, 8'h00);
		i_ctl_model.send_byte(8'h5a, ak);
		bus(1, CONTROL_OFS, 8'h17);
		bus(1, CONTROL_OFS, 8'h13);
		cyc(3);
		`CHECK({scl_oe, sda_oe}, 2'b00)
		i_ctl_model.send_byte(8'h66, ak);
		`CHECK(ak, 1'b0)
		bus(0, STATUS_ONE_OFS, 8'h00);
		bus(0, DATA_OFS, 8'h00);
		`CHECK(q[7:0], 8'h5a)
		i_ctl_model.stop_cond();
		bus(0, STATUS_TWO_OFS, 8'h00);
	endtask : sc_release

	task automatic sc_refuse;
		i_ctl_model.start_cond();
		i_ctl_model.send_byte(8'h54, ak);
		`CHECK({ak, scl_oe}, 2'b00)
		i_ctl_model.send_byte(8'h52, ak);
		`CHECK(ak, 1'b0)
		i_ctl_model.stop_cond();
		i_ctl_model.start_cond();
		i_ctl_model.send_byte(GENERAL_CALL, ak);
		`CHECK(ak, 1'b0)
		i_ctl_model.stop_cond();
		bus(1, CONTROL_OFS, 8'h33);
		i_ctl_model.start_cond();
		i_ctl_model.send_byte(GENERAL_CALL, ak);
		bus(0, STATUS_TWO_OFS, 8'h00);
		`CHECK({ak, q[ST2_GCALL_BIT]}, 2'b11)
		bus(0, STATUS_ONE_OFS, 8'h00);
		i_ctl_model.stop_cond();
		bus(1, CONTROL_OFS, 8'h03);
		i_ctl_model.start_cond();
		i_ctl_model.send_byte(8'h52, ak);
		bus(0, STATUS_ONE_OFS, 8'h00);
		`CHECK({ak, q[ST1_ADDR_BIT]}, 2'b01)
		i_ctl_model.send_byte(8'h3c, ak);
		bus(0, STATUS_ONE_OFS, 8'h00);
		bus(0, DATA_OFS, 8'h00);
		`CHECK({ak, q[7:0]}, 9'h03c)
		i_ctl_model.stop_cond();
		bus(0, STATUS_TWO_OFS, 8'h00);
	endtask : sc_refuse

	task automatic sc_tx;
		bus(1, CONTROL_OFS, 8'h13);
		i_ctl_model.start_cond();
		i_ctl_model.send_byte(8'h53, ak);
		bus(0, STATUS_ONE_OFS, 8'h00);
		`CHECK(q[ST1_TX_BIT], 1'b1)
		cyc(20);
		`CHECK(scl_oe, 1'b1)
		bus(1, DATA_OFS, 8'h3c);
		i_ctl_model.recv_byte(1'b1, rb);
		bus(0, STATUS_ONE_OFS, 8'h00);
		`CHECK({rb, q[ST1_BYTE_BIT]}, 9'h079)
		bus(1, DATA_OFS, 8'hc3);
		i_ctl_model.recv_byte(1'b0, rb);
		cyc(3);
		`CHECK({rb, scl_oe}, 9'h186)
		bus(0, STATUS_TWO_OFS, 8'h00);
		`CHECK(q[ST2_AF_BIT], 1'b1)
		i_ctl_model.stop_cond();
		bus(0, STATUS_TWO_OFS, 8'h00);
	endtask : sc_tx

	task automatic sc_bus_error_flag;
		i_ctl_model.start_cond();
		i_ctl_model.send_byte(8'h52, ak);
		bus(0, STATUS_ONE_OFS, 8'h00);
		repeat (4) i_ctl_model.bit_cycle(1'b0, ak);
		i_ctl_model.start_cond();
		bus(0, STATUS_TWO_OFS, 8'h00);
		`CHECK({q[ST2_BUS_ERROR_FLAG_BIT], scl_oe}, 2'b10)
		i_ctl_model.send_byte(8'h52, ak);
		`CHECK(ak, 1'b1)
		bus(0, STATUS_ONE_OFS, 8'h00);
		i_ctl_model.stop_cond();
		bus(0, STATUS_TWO_OFS, 8'h00);
	endtask : sc_bus_error_flag

	task automatic sc_ten;
		bus(1, OWN_ADDR_TWO_OFS, 8'h05);
		bus(1, OWN_ADDR_ONE_OFS, 8'h6b);
		i_ctl_model.start_cond();
		i_ctl_model.send_byte(8'hf6, ak);
		`CHECK(ak, 1'b0)
		i_ctl_model.start_cond();
		i_ctl_model.send_byte(8'hf4, ak);
		`CHECK(ak, 1'b1)
		i_ctl_model.send_byte(8'h6b, ak);
		bus(0, STATUS_ONE_OFS, 8'h00);
		`CHECK({ak, q[ST1_TX_BIT], q[ST1_ADDR_BIT]}, 3'b101)
		i_ctl_model.start_cond();
		i_ctl_model.send_byte(8'hf5, ak);
		bus(0, STATUS_ONE_OFS, 8'h00);
		`CHECK({ak, q[ST1_TX_BIT]}, 2'b11)
		bus(1, DATA_OFS, 8'h99);
		i_ctl_model.recv_byte(1'b0, rb);
		`CHECK(rb, 8'h99)
		i_ctl_model.stop_cond();
		bus(0, STATUS_TWO_OFS, 8'h00);
	endtask : sc_ten

	initial begin
		cyc(6);
		reset <= 1'b0;
		cyc(1);
		sc_regs();
		sc_rx();
		sc_release();
		sc_refuse();
		sc_tx();
		sc_bus_error_flag();
		sc_ten();
		finish_test();
	end
endmodule : tb

`default_nettype wire
